/* src/jdc_config_regs.sv */
module jdc_config_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        external_resistor_type,
  output logic             hook_threshold_select,
  output logic      [1:0]  hook_insert_min_impedance,
  output logic             headphone_coupling_select,
  output logic             double_sense_current,
  output logic             headset_detect_enable,
  output logic      [10:0] hook_max_ohms,
  output logic      [10:0] mic_min_ohms,
  output logic      [7:0]  insert_min_ohms
);

  // ----------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------
  logic        accept;
  logic        hit;
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic        wr_now;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [7:0]  cfg_image;
  logic [7:0]  fwd_image;

  assign accept    = hsel & hready & htrans[1];
  assign hit       = (haddr == jdc_pkg::JDC_REG_ADDR);
  assign wr_now    = wr_pend_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_comb begin
    wr_pend_next = accept & hwrite & hit;
    fwd_image    = jdc_pkg::JDC_RESET;
    fwd_image[jdc_pkg::JDC_IMP_MSB:jdc_pkg::JDC_CUR_BIT] =
      hwdata[jdc_pkg::JDC_IMP_MSB:jdc_pkg::JDC_CUR_BIT];
    fwd_image[jdc_pkg::JDC_THR_BIT] = hwdata[jdc_pkg::JDC_THR_BIT];
    fwd_image[jdc_pkg::JDC_EN_BIT]  = hwdata[jdc_pkg::JDC_EN_BIT];
    hrdata_next = 32'h00000000;
    // Forward a write still in its data phase so a back-to-back read sees it
    if (accept && !hwrite && hit) begin
      hrdata_next[7:0] = wr_now ? fwd_image : cfg_image;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      hrdata_reg  <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      hrdata_reg  <= hrdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  jdc_field #(.W(1), .RST(jdc_pkg::JDC_THR_RST)) u_thr (
    .clk   (hclk),
    .rst_n (hresetn),
    .we    (wr_now),
    .d     (hwdata[jdc_pkg::JDC_THR_BIT]),
    .q     (hook_threshold_select)
  );

  // Reserved code 3 is stored as written; the decode below treats it as no limit
  jdc_field #(.W(2), .RST(jdc_pkg::JDC_IMP_RST)) u_imp (
    .clk   (hclk),
    .rst_n (hresetn),
    .we    (wr_now),
    .d     (hwdata[jdc_pkg::JDC_IMP_MSB:jdc_pkg::JDC_IMP_LSB]),
    .q     (hook_insert_min_impedance)
  );

  jdc_field #(.W(1), .RST(jdc_pkg::JDC_CPL_RST)) u_cpl (
    .clk   (hclk),
    .rst_n (hresetn),
    .we    (wr_now),
    .d     (hwdata[jdc_pkg::JDC_CPL_BIT]),
    .q     (headphone_coupling_select)
  );

  jdc_field #(.W(1), .RST(jdc_pkg::JDC_CUR_RST)) u_cur (
    .clk   (hclk),
    .rst_n (hresetn),
    .we    (wr_now),
    .d     (hwdata[jdc_pkg::JDC_CUR_BIT]),
    .q     (double_sense_current)
  );

  jdc_field #(.W(1), .RST(jdc_pkg::JDC_EN_RST)) u_en (
    .clk   (hclk),
    .rst_n (hresetn),
    .we    (wr_now),
    .d     (hwdata[jdc_pkg::JDC_EN_BIT]),
    .q     (headset_detect_enable)
  );

  always_comb begin
    cfg_image = jdc_pkg::JDC_RESET;
    cfg_image[jdc_pkg::JDC_THR_BIT] = hook_threshold_select;
    cfg_image[jdc_pkg::JDC_IMP_MSB:jdc_pkg::JDC_IMP_LSB] = hook_insert_min_impedance;
    cfg_image[jdc_pkg::JDC_CPL_BIT] = headphone_coupling_select;
    cfg_image[jdc_pkg::JDC_CUR_BIT] = double_sense_current;
    cfg_image[jdc_pkg::JDC_EN_BIT]  = headset_detect_enable;
  end

  // ----------------------------------------------------------------
  // Strap synchroniser and limit decode
  // ----------------------------------------------------------------
  logic        ext_s1_reg;
  logic        ext_s2_reg;
  logic [10:0] hook_reg;
  logic [10:0] hook_next;
  logic [10:0] mic_reg;
  logic [10:0] mic_next;
  logic [7:0]  ins_reg;
  logic [7:0]  ins_next;

  always_comb begin
    if (hook_threshold_select) begin
      hook_next = jdc_pkg::JDC_OHM_HOOK_HIGH;
      mic_next  = headphone_coupling_select ? jdc_pkg::JDC_OHM_MIC_HIGH_DC
                                            : jdc_pkg::JDC_OHM_MIC_HIGH_AC;
    end else begin
      mic_next  = jdc_pkg::JDC_OHM_MIC_LOW;
      hook_next = headphone_coupling_select ? jdc_pkg::JDC_OHM_HOOK_LOW_DC
                                            : jdc_pkg::JDC_OHM_HOOK_LOW_AC;
    end
    // Field is meaningless with the other resistor type
    if (ext_s2_reg) begin
      ins_next = jdc_pkg::JDC_OHM_INS_NONE;
    end else begin
      case (hook_insert_min_impedance)
        jdc_pkg::JDC_IMP_150: ins_next = jdc_pkg::JDC_OHM_INS_150;
        jdc_pkg::JDC_IMP_100: ins_next = jdc_pkg::JDC_OHM_INS_100;
        jdc_pkg::JDC_IMP_50:  ins_next = jdc_pkg::JDC_OHM_INS_50;
        default:              ins_next = jdc_pkg::JDC_OHM_INS_NONE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      hook_reg   <= jdc_pkg::JDC_OHM_HOOK_LOW_AC;
      mic_reg    <= jdc_pkg::JDC_OHM_MIC_LOW;
      ins_reg    <= jdc_pkg::JDC_OHM_INS_150;
    end else begin
      ext_s1_reg <= external_resistor_type;
      ext_s2_reg <= ext_s1_reg;
      hook_reg   <= hook_next;
      mic_reg    <= mic_next;
      ins_reg    <= ins_next;
    end
  end

  assign hook_max_ohms   = hook_reg;
  assign mic_min_ohms    = mic_reg;
  assign insert_min_ohms = ins_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_reserved_read_zero: assert property (
    (hrdata[jdc_pkg::JDC_RSV_HI_BIT] == 1'b0) && (hrdata[jdc_pkg::JDC_RSV_LO_BIT] == 1'b0))
    else $error("reserved bit read as one");

  a_hook_limit_map: assert property (
    ##1 (hook_max_ohms == ($past(hook_threshold_select) ? 11'h2a8
         : ($past(headphone_coupling_select) ? 11'h096 : 11'h140)))
        && (mic_min_ohms == (!$past(hook_threshold_select) ? 11'h320
         : ($past(headphone_coupling_select) ? 11'h6d6 : 11'h546))))
    else $error("hook or mic limit wrong");

  a_insert_imp_map: assert property (
    (!ext_s2_reg && hook_insert_min_impedance == 2'h1) |=> (insert_min_ohms == 8'h64))
    else $error("insert impedance decode wrong");

  a_coupling_write: assert property (
    accept && hwrite && hit ##1 hready |=> headphone_coupling_select == $past(hwdata[3]))
    else $error("coupling bit not written");

  a_current_write: assert property (
    wr_now |=> double_sense_current == $past(hwdata[2]))
    else $error("current bit not written");

  a_enable_write: assert property (
    wr_now |=> headset_detect_enable == $past(hwdata[1]) && cfg_image[1] == $past(hwdata[1]))
    else $error("enable bit not written");

  a_reset_clear: assert property (
    !$past(hresetn) |-> (cfg_image == 8'h00 && !headset_detect_enable))
    else $error("register not clear after reset");

  a_hold_no_write: assert property (
    !wr_now |=> $stable(cfg_image))
    else $error("field changed without write");

  a_read_back: assert property (
    (accept && !hwrite && hit && !wr_now) |=> hrdata == {24'h000000, $past(cfg_image)})
    else $error("read data mismatch");

  a_unmapped_read: assert property (
    (accept && !hwrite && !hit) |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");

  c_write_reg: cover property (wr_now);
  c_read_reg: cover property (accept && !hwrite && hit);
  c_write_then_read: cover property (wr_now && accept && !hwrite && hit);
  c_reserved_code: cover property (hook_insert_min_impedance == jdc_pkg::JDC_IMP_RSVD);

endmodule

/* src/jdc_field.sv */
module jdc_field #(
  parameter int unsigned    W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         we,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] val_reg;
  logic [W-1:0] val_next;

  always_comb begin
    val_next = we ? d : val_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_reg <= RST;
    end else begin
      val_reg <= val_next;
    end
  end

  assign q = val_reg;

endmodule

/* src/jdc_pkg.sv */
package jdc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  JDC_REG_INDEX = 8'h1a;
  localparam logic [31:0] JDC_REG_ADDR  = {22'h000000, JDC_REG_INDEX, 2'b00};
  localparam logic [7:0]  JDC_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int JDC_RSV_HI_BIT = 7;
  localparam int JDC_THR_BIT    = 6;
  localparam int JDC_IMP_MSB    = 5;
  localparam int JDC_IMP_LSB    = 4;
  localparam int JDC_CPL_BIT    = 3;
  localparam int JDC_CUR_BIT    = 2;
  localparam int JDC_EN_BIT     = 1;
  localparam int JDC_RSV_LO_BIT = 0;

  localparam logic       JDC_THR_RST = 1'b0;
  localparam logic [1:0] JDC_IMP_RST = 2'h0;
  localparam logic       JDC_CPL_RST = 1'b0;
  localparam logic       JDC_CUR_RST = 1'b0;
  localparam logic       JDC_EN_RST  = 1'b0;

  // ----------------------------------------------------------------
  // Impedance codes and limits in ohms
  // ----------------------------------------------------------------
  localparam logic [1:0]  JDC_IMP_150  = 2'h0;
  localparam logic [1:0]  JDC_IMP_100  = 2'h1;
  localparam logic [1:0]  JDC_IMP_50   = 2'h2;
  localparam logic [1:0]  JDC_IMP_RSVD = 2'h3;

  localparam logic [10:0] JDC_OHM_MIC_LOW     = 11'h320; // 800
  localparam logic [10:0] JDC_OHM_HOOK_LOW_AC = 11'h140; // 320
  localparam logic [10:0] JDC_OHM_HOOK_LOW_DC = 11'h096; // 150
  localparam logic [10:0] JDC_OHM_HOOK_HIGH   = 11'h2a8; // 680
  localparam logic [10:0] JDC_OHM_MIC_HIGH_AC = 11'h546; // 1350
  localparam logic [10:0] JDC_OHM_MIC_HIGH_DC = 11'h6d6; // 1750
  localparam logic [7:0]  JDC_OHM_INS_150     = 8'h96;
  localparam logic [7:0]  JDC_OHM_INS_100     = 8'h64;
  localparam logic [7:0]  JDC_OHM_INS_50      = 8'h32;
  localparam logic [7:0]  JDC_OHM_INS_NONE    = 8'h00;

endpackage

/* tb/jdc_config_regs_test.sv */
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR t=%0t got %h expected %h", $time, got, exp); end end

module jdc_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] A = jdc_pkg::JDC_REG_ADDR;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_res;
  logic        thr, cpl, cur, en;
  logic [1:0]  htrans, imp;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [10:0] hook_max, mic_min;
  logic [7:0]  ins_min;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;

  jdc_config_regs jdc_config_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_resistor_type(ext_res), .hook_threshold_select(thr),
    .hook_insert_min_impedance(imp), .headphone_coupling_select(cpl),
    .double_sense_current(cur), .headset_detect_enable(en),
    .hook_max_ohms(hook_max), .mic_min_ohms(mic_min), .insert_min_ohms(ins_min)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic addr_phase(logic wr, logic [31:0] a);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic data_phase(logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_reg(logic [31:0] a, output logic [31:0] d);
    addr_phase(1'b0, a);
    data_phase(32'h0, d);
  endtask

  // Two extra edges so the decoded ohm outputs have caught up too
  task automatic wr_reg(logic [31:0] a, logic [31:0] v);
    logic [31:0] d;
    addr_phase(1'b1, a);
    data_phase(v, d);
    repeat (2) @(posedge hclk);
  endtask

  task automatic check_img(logic [7:0] img);
    logic [31:0] d;
    rd_reg(A, d);
    `CHK(d, {24'h0, img})
    `CHK(thr, img[6])
    `CHK(imp, img[5:4])
    `CHK(cpl, img[3])
    `CHK(cur, img[2])
    `CHK(en, img[1])
    `CHK(hresp, 1'b0)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check_img(8'h00);
    `CHK(hook_max, jdc_pkg::JDC_OHM_HOOK_LOW_AC)
    `CHK(mic_min, jdc_pkg::JDC_OHM_MIC_LOW)
    `CHK(ins_min, jdc_pkg::JDC_OHM_INS_150)
    $display("test reset done");
  endtask

  task automatic t_reserved();
    wr_reg(A, 32'hffffffff);
    check_img(8'h7e);
    wr_reg(A, 32'h00000081);
    check_img(8'h00);
    $display("test reserved done");
  endtask

  // Every threshold and coupling pairing, with enable and current toggling
  task automatic t_decode();
    logic [7:0] w;
    for (int i = 0; i < 4; i++) begin
      w = {1'b0, i[1], 2'b00, i[0], i[0], ~i[0], 1'b0};
      wr_reg(A, {24'h0, w});
      check_img(w);
      `CHK(hook_max, i[1] ? 11'h2a8 : (i[0] ? 11'h096 : 11'h140))
      `CHK(mic_min, i[1] ? (i[0] ? 11'h6d6 : 11'h546) : 11'h320)
    end
    $display("test decode done");
  endtask

  task automatic t_impedance();
    logic [7:0] tbl [4] = '{8'h96, 8'h64, 8'h32, 8'h00};
    for (int c = 0; c < 4; c++) begin
      wr_reg(A, {24'h0, 2'b00, c[1:0], 4'h0});
      check_img({2'b00, c[1:0], 4'h0});
      `CHK(ins_min, tbl[c])
    end
    wr_reg(A, 32'h00000010);
    ext_res <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK(ins_min, 8'h00)
    ext_res <= 1'b0;
    repeat (4) @(posedge hclk);
    `CHK(ins_min, 8'h64)
    $display("test impedance done");
  endtask

  // The raw index 0x1a and the next word must both miss the register
  task automatic t_unmapped();
    logic [31:0] d;
    wr_reg(A, 32'h0000000c);
    wr_reg(A + 32'h4, 32'h000000ff);
    wr_reg(32'h0000001a, 32'h000000ff);
    check_img(8'h0c);
    rd_reg(A + 32'h4, d);
    `CHK(d, 32'h0)
    $display("test unmapped done");
  endtask

  task automatic t_back2back();
    logic [31:0] d;
    addr_phase(1'b1, A);
    hwdata <= 32'h00000046;
    addr_phase(1'b0, A);
    data_phase(32'h0, d);
    `CHK(d, 32'h00000046)
    check_img(8'h46);
    $display("test back to back done");
  endtask

  // Reset in mid-run must clear written fields and decoded limits again
  task automatic t_midrun_reset();
    wr_reg(A, 32'h0000007e);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK(hrdata, 32'h00000000)
    `CHK(en, jdc_pkg::JDC_EN_RST)
    `CHK(cpl, jdc_pkg::JDC_CPL_RST)
    hresetn <= 1'b1;
    t_reset();
    $display("test midrun reset done");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, run control
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Whole run is about 110 cycles; the ceiling leaves ample margin
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    ext_res = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_reserved();
    t_decode();
    t_impedance();
    t_unmapped();
    t_back2back();
    t_midrun_reset();
    print_verdict();
  end
endmodule
